// *** shared/sfl_pkg.sv ***
`default_nettype none
package sfl_pkg;
	// ******************************
	// Widths and reset values
	// ******************************
	localparam int CAP_W = 16;
	localparam int ACC_W = 32;
	localparam int FRAC_W = 16;
	localparam logic [CAP_W-1:0] CAP_RESET = 16'h0000;
	localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;
	localparam logic [CAP_W-1:0] SET_DISABLED = 16'hffff;
	localparam int FLAG_INIT_BIT = 1;
	localparam int FLAG_FINAL_BIT = 0;
	localparam int FLAG_W = 2;
	localparam logic [FLAG_W-1:0] FLAGS_RESET = 2'h0;
endpackage
`default_nettype wire

// *** core/sfl_hyst_flag.sv ***
`timescale 1ns/100ps
`default_nettype none
module sfl_hyst_flag (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic update,
	input wire logic [15:0] level,
	input wire logic [15:0] set_level,
	input wire logic [15:0] clear_level,
	input wire logic set_disabled,
	output logic flag_q
);
	// ******************************
	// Hysteresis flag
	// ******************************
	wire logic below_set;
	wire logic above_clear;
	assign below_set = !set_disabled && (level < set_level);
	assign above_clear = level > clear_level;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			flag_q <= 1'b0;
		end else if (update) begin
			// Set takes priority if the thresholds overlap
			if (below_set) begin
				flag_q <= 1'b1;
			end else if (flag_q && above_clear) begin
				flag_q <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// *** core/sfl_soc_flags.sv ***
// Behaviour
// RULE1 - Accumulate sensed charge both directions
// RULE2 - Exactly two warning flags in status
// RULE3 - Set initial flag below its level
// RULE4 - Clear initial flag above clear level
// RULE5 - Set final flag below its level
// RULE6 - Set level minus one disables final
// RULE7 - Clear final only when already set
// RULE8 - Report uncompensated remaining and full values
// RULE9 - Re-evaluate on update, hold between levels
`timescale 1ns/100ps
`default_nettype none
module sfl_soc_flags (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic sample_valid,
	input wire logic signed [15:0] sense_charge,
	input wire logic load_start,
	input wire logic [sfl_pkg::CAP_W-1:0] start_remaining,
	input wire logic [sfl_pkg::CAP_W-1:0] full_capacity,
	input wire logic [sfl_pkg::CAP_W-1:0] compensation_loss,
	input wire logic [sfl_pkg::CAP_W-1:0] initial_warn_set_level,
	input wire logic [sfl_pkg::CAP_W-1:0] initial_warn_clear_level,
	input wire logic [sfl_pkg::CAP_W-1:0] final_warn_set_level,
	input wire logic [sfl_pkg::CAP_W-1:0] final_warn_clear_level,
	output logic [sfl_pkg::CAP_W-1:0] remaining_charge_value,
	output logic [sfl_pkg::CAP_W-1:0] compensated_full_value,
	output logic [sfl_pkg::CAP_W-1:0] uncompensated_remaining,
	output logic [sfl_pkg::CAP_W-1:0] uncompensated_full,
	output logic [sfl_pkg::FLAG_W-1:0] flag_status,
	output logic remaining_updated
);
	import sfl_pkg::*;

	// ******************************
	// Charge integration
	// ******************************
	// Fixed point: upper CAP_W bits are mAh, lower FRAC_W bits a fraction
	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] acc_d;
	logic upd_q;
	wire logic [ACC_W-1:0] charge_ext;
	wire logic [ACC_W:0] acc_sum;
	wire logic [ACC_W-1:0] acc_max;
	wire logic [CAP_W-1:0] nom_rem;
	wire logic [CAP_W-1:0] comp_rem;
	wire logic [CAP_W-1:0] comp_full;

	assign charge_ext = {{(ACC_W-16){sense_charge[15]}}, sense_charge};
	assign acc_max = {full_capacity, {FRAC_W{1'b0}}};
	assign acc_sum = {1'b0, acc_q} + {charge_ext[ACC_W-1], charge_ext};

	// Saturate at empty and at full rather than wrap
	always_comb begin
		acc_d = acc_q;
		if (load_start) begin
			acc_d = {start_remaining, {FRAC_W{1'b0}}};
		end else if (sample_valid) begin
			if (sense_charge[15] && acc_sum[ACC_W]) begin
				acc_d = ACC_RESET;
			end else if (!sense_charge[15] && (acc_sum[ACC_W] || acc_sum[ACC_W-1:0] > acc_max)) begin
				acc_d = acc_max;
			end else begin
				acc_d = acc_sum[ACC_W-1:0]; // RULE1
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			acc_q <= ACC_RESET;
			upd_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			upd_q <= load_start || sample_valid;
		end
	end

	// ******************************
	// Capacity reports
	// ******************************
	assign nom_rem = acc_q[ACC_W-1:FRAC_W];
	assign comp_rem = (nom_rem > compensation_loss) ? nom_rem - compensation_loss : CAP_RESET;
	assign comp_full = (full_capacity > compensation_loss) ?
		full_capacity - compensation_loss : CAP_RESET;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			remaining_charge_value <= CAP_RESET;
			compensated_full_value <= CAP_RESET;
			uncompensated_remaining <= CAP_RESET;
			uncompensated_full <= CAP_RESET;
			remaining_updated <= 1'b0;
		end else begin
			remaining_updated <= upd_q;
			if (upd_q) begin
				remaining_charge_value <= comp_rem;
				compensated_full_value <= comp_full;
				uncompensated_remaining <= nom_rem; // RULE8
				uncompensated_full <= full_capacity; // RULE8
			end
		end
	end

	// ******************************
	// Warning flags
	// ******************************
	// Compare against the freshly published value, one cycle after it lands
	logic init_flag;
	logic final_flag;
	wire logic final_disabled;
	assign final_disabled = final_warn_set_level == SET_DISABLED;

	sfl_hyst_flag u_init (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.update(remaining_updated), // RULE9
		.level(remaining_charge_value),
		.set_level(initial_warn_set_level), // RULE3
		.clear_level(initial_warn_clear_level), // RULE4
		.set_disabled(1'b0),
		.flag_q(init_flag)
	);

	sfl_hyst_flag u_final (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.update(remaining_updated), // RULE9
		.level(remaining_charge_value),
		.set_level(final_warn_set_level), // RULE5
		.clear_level(final_warn_clear_level), // RULE7
		.set_disabled(final_disabled), // RULE6
		.flag_q(final_flag)
	);

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			flag_status <= FLAGS_RESET;
		end else begin
			flag_status[FLAG_INIT_BIT] <= init_flag; // RULE2
			flag_status[FLAG_FINAL_BIT] <= final_flag; // RULE2
		end
	end

	// ******************************
	// Checks
	// ******************************
	// Each flag step: refresh edge, then flag edge, then status edge
	sequence init_below_seq;
		remaining_updated && remaining_charge_value < initial_warn_set_level;
	endsequence
	sequence init_above_seq;
		remaining_updated && remaining_charge_value > initial_warn_clear_level
		&& !(remaining_charge_value < initial_warn_set_level);
	endsequence
	sequence final_below_seq;
		remaining_updated && !final_disabled && remaining_charge_value < final_warn_set_level;
	endsequence
	sequence final_above_seq;
		remaining_updated && final_flag && remaining_charge_value > final_warn_clear_level
		&& (final_disabled || !(remaining_charge_value < final_warn_set_level));
	endsequence
	sequence init_shown_seq;
		##1 flag_status[FLAG_INIT_BIT];
	endsequence
	sequence init_gone_seq;
		##1 !flag_status[FLAG_INIT_BIT];
	endsequence
	sequence final_shown_seq;
		##1 flag_status[FLAG_FINAL_BIT];
	endsequence
	sequence final_gone_seq;
		##1 !flag_status[FLAG_FINAL_BIT];
	endsequence

	chk_init_set: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE3
		init_below_seq |=> init_shown_seq) else $error("initial flag not set");
	chk_init_clear: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE4
		init_above_seq |=> init_gone_seq) else $error("initial flag not cleared");
	chk_final_set: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE5
		final_below_seq |=> final_shown_seq) else $error("final flag not set");
	chk_final_off: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE6
		final_disabled && !final_flag |=> !final_flag) else $error("disabled final flag rose");
	chk_final_clear: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE7
		final_above_seq |=> final_gone_seq) else $error("final flag not cleared");
	chk_flag_hold: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE9
		!remaining_updated |=> $stable(init_flag) && $stable(final_flag))
		else $error("flag moved without update");
	chk_charge_up: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE1
		sample_valid && !load_start && !sense_charge[15] |=> acc_q >= $past(acc_q))
		else $error("charge did not rise");
	chk_charge_down: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE1
		sample_valid && !load_start && sense_charge[15] |=> acc_q <= $past(acc_q))
		else $error("discharge did not fall");
	chk_nominal_out: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE8
		upd_q |=> uncompensated_remaining == $past(nom_rem)) else $error("nominal value stale");
	chk_init_rise: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE3
		$rose(init_flag) |-> $past(remaining_updated)
		&& $past(remaining_charge_value) < $past(initial_warn_set_level))
		else $error("initial flag rose without cause");
	chk_init_fall: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE4
		$fell(init_flag) |-> $past(remaining_updated)
		&& $past(remaining_charge_value) > $past(initial_warn_clear_level))
		else $error("initial flag fell without cause");
	chk_final_rise: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE5
		$rose(final_flag) |-> $past(remaining_updated) && !$past(final_disabled)
		&& $past(remaining_charge_value) < $past(final_warn_set_level))
		else $error("final flag rose without cause");
	chk_final_fall: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE7
		$fell(final_flag) |-> $past(remaining_updated)
		&& $past(remaining_charge_value) > $past(final_warn_clear_level))
		else $error("final flag fell without cause");
	chk_status_pair: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE2
		flag_status[FLAG_INIT_BIT] == $past(init_flag)
		&& flag_status[FLAG_FINAL_BIT] == $past(final_flag)) else $error("status word skewed");
	chk_load_value: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE1
		load_start |=> acc_q == {$past(start_remaining), {FRAC_W{1'b0}}})
		else $error("start value not loaded");
	chk_comp_full: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE8
		remaining_updated |-> compensated_full_value == $past(comp_full))
		else $error("compensated full stale");
endmodule
`default_nettype wire

// *** dv/sfl_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module sfl_host_model (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic remaining_updated,
	input wire logic [sfl_pkg::FLAG_W-1:0] flag_status,
	output logic [sfl_pkg::FLAG_W-1:0] host_flags_q
);
	import sfl_pkg::*;
	logic [1:0] pend_q;
	// Flags trail the refresh pulse by two cycles, so the read waits for them
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pend_q <= 2'h0;
			host_flags_q <= FLAGS_RESET;
		end else begin
			pend_q <= {pend_q[0], remaining_updated};
			if (pend_q[1]) host_flags_q <= flag_status;
		end
	end
endmodule
`default_nettype wire

// *** dv/sfl_soc_flags_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin errors++; \
	$display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module sfl_soc_flags_tb;
	import sfl_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic sample_valid = 1'b0;
	logic load_start = 1'b0;
	logic signed [15:0] sense_charge = 16'sh0000;
	logic [CAP_W-1:0] start_v = 16'h0000, full_v = 16'h0400, loss_v = 16'h0010;
	logic [CAP_W-1:0] set1 = 16'h0200, clr1 = 16'h0280, setf = 16'h0100, clrf = 16'h0180;
	wire logic [CAP_W-1:0] rem, cfull, urem, ufull;
	wire logic [FLAG_W-1:0] flags, host_flags;
	wire logic upd;
	int errors = 0;
	int total_checks = 0;
	always #4 clk_sys = ~clk_sys;
	sfl_soc_flags u_sfl_soc_flags (.clk_sys(clk_sys), .reset_n(reset_n),
		.sample_valid(sample_valid), .sense_charge(sense_charge), .load_start(load_start),
		.start_remaining(start_v), .full_capacity(full_v), .compensation_loss(loss_v),
		.initial_warn_set_level(set1), .initial_warn_clear_level(clr1),
		.final_warn_set_level(setf), .final_warn_clear_level(clrf),
		.remaining_charge_value(rem), .compensated_full_value(cfull),
		.uncompensated_remaining(urem), .uncompensated_full(ufull),
		.flag_status(flags), .remaining_updated(upd));
	sfl_host_model u_sfl_host_model (.clk_sys(clk_sys), .reset_n(reset_n),
		.remaining_updated(upd), .flag_status(flags), .host_flags_q(host_flags));
	task automatic end_of_test;
		if (errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ******************************
	// Load or accumulate, then read flags
	// ******************************
	task automatic op(input logic ld, input logic [15:0] v, input int n, input logic [1:0] ef);
		int i;
		@(posedge clk_sys);
		load_start <= ld;
		sample_valid <= !ld;
		start_v <= v;
		sense_charge <= v;
		repeat (n) @(posedge clk_sys);
		load_start <= 1'b0;
		sample_valid <= 1'b0;
		i = 0;
		// Earlier pulses of a burst are skipped; only the last one counts
		do begin
			@(posedge clk_sys);
			#1;
			i++;
		end while (upd !== 1'b1 && i < 8);
		`CHK("update", 1'b1, upd)
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK("flags", ef, flags)
		@(posedge clk_sys);
		#1;
		`CHK("host_flags", ef, host_flags)
	endtask
	initial begin
		#20000;
		errors++;
		end_of_test();
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		#1;
		`CHK("reset_flags", FLAGS_RESET, flags)
		`CHK("reset_rem", CAP_RESET, rem)
		op(1'b1, 16'h0310, 1, 2'h0);
		`CHK("cfull", 16'h03f0, cfull)
		`CHK("ufull", 16'h0400, ufull)
		`CHK("urem", 16'h0310, urem)
		`CHK("rem", 16'h0300, rem)
		op(1'b1, 16'h0210, 1, 2'h0);
		op(1'b1, 16'h0200, 1, 2'h2);
		op(1'b1, 16'h0280, 1, 2'h2);
		op(1'b1, 16'h02a0, 1, 2'h0);
		op(1'b1, 16'h0270, 1, 2'h0);
		op(1'b1, 16'h0100, 1, 2'h3);
		op(1'b1, 16'h0150, 1, 2'h3);
		op(1'b1, 16'h01a0, 1, 2'h2);
		op(1'b0, 16'h8000, 1, 2'h2);
		`CHK("urem_dsg", 16'h019f, urem)
		op(1'b0, 16'h4000, 2, 2'h2);
		`CHK("urem_chg", 16'h01a0, urem)
		`CHK("rem_chg", 16'h0190, rem)
		@(posedge clk_sys);
		setf <= SET_DISABLED;
		op(1'b1, 16'h0020, 1, 2'h2);
		// Second reset in mid-run, then the saturation corners
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		#1;
		`CHK("rst2_flags", FLAGS_RESET, flags)
		`CHK("rst2_urem", CAP_RESET, urem)
		op(1'b1, 16'h0090, 1, 2'h2);
		op(1'b0, 16'h8000, 1, 2'h2);
		op(1'b1, 16'h0000, 1, 2'h2);
		op(1'b0, 16'h8000, 1, 2'h2);
		`CHK("urem_empty", CAP_RESET, urem)
		op(1'b1, 16'h0400, 1, 2'h0);
		op(1'b0, 16'h4000, 1, 2'h0);
		`CHK("urem_full", 16'h0400, urem)
		end_of_test();
	end
endmodule
`default_nettype wire
